// ==== core/garage_door_cfg.svh ====
/*
  Timing constants for the garage door controller.
  Assumes a 100 MHz clock on CLK.
*/
`ifndef GARAGE_DOOR_CFG_SVH
`define GARAGE_DOOR_CFG_SVH
`define CLK_PERIOD_NS      10
`define CLK_PERIOD_PS      10000
`define LAMP_TICK_MS       100
`define LAMP_TICK_CYCLES   ((`LAMP_TICK_MS * 1000000) / (`CLK_PERIOD_PS / 1000))
`define LAMP_TICK_COUNTS   1800
`define LAMP_TICK_W        24
`define LAMP_COUNT_W       11
`endif

// ==== core/garage_door_controller.sv ====
/*
  Garage door controller: door sequence with a parallel safety lamp.
  Assumes switch inputs are asynchronous and the motor honours the two commands.
*/
`timescale 1ns/1ps
`include "garage_door_cfg.svh"

// What this block does
// - Powerup starts in door-down, door closed.
// - Press then release from down starts raising.
// - Raise command only while raising.
// - Up limit ends raising into door-up.
// - Press-release from up starts lowering; lower command.
// - Down limit ends lowering into door-down.
// - Wait-state release also sets lamp state.
// - Lamp output follows lamp state.
// - Lamp clears itself after three minutes.
// - Lamp runs in parallel with door sequence.
// - Initial state differs only at powerup.
// - Lamp timer counts 1800 tenths of second.
// - Transition leaves origin, enters target next cycle.
module garage_door_controller
(
  // Clock and reset.
  input  wire logic CLK,
  input  wire logic RST,
  // Switch inputs.
  input  wire logic DOOR_BUTTON,
  input  wire logic UP_LIMIT,
  input  wire logic DOWN_LIMIT,
  // Motor and lamp outputs.
  output logic      RAISE_CMD,
  output logic      LOWER_CMD,
  output logic      LAMP_OUT
);
  import garage_door_pkg::*;

  localparam int unsigned TICK_CYCLES = `LAMP_TICK_CYCLES;
  localparam logic [`LAMP_TICK_W-1:0]  TICK_LAST  = `LAMP_TICK_W'(TICK_CYCLES - 1);
  localparam logic [`LAMP_COUNT_W-1:0] COUNT_LAST = `LAMP_COUNT_W'(`LAMP_TICK_COUNTS - 1);

  logic                     door_button;
  logic                     up_limit;
  logic                     down_limit;
  door_state_t              state;
  door_state_t              next_state;
  logic                     lamp_state;
  logic                     next_lamp_state;
  logic [`LAMP_TICK_W-1:0]  tick;
  logic [`LAMP_TICK_W-1:0]  next_tick;
  logic [`LAMP_COUNT_W-1:0] count;
  logic [`LAMP_COUNT_W-1:0] next_count;
  logic                     lamp_timer_done;
  logic                     lamp_set;
  logic                     next_raise;
  logic                     next_lower;

  // ****************************************
  // Input synchronisers.
  // ****************************************
  input_sync u_sync_button (.clk(CLK), .rst(RST), .din(DOOR_BUTTON), .dout(door_button));
  input_sync u_sync_up     (.clk(CLK), .rst(RST), .din(UP_LIMIT),    .dout(up_limit));
  input_sync u_sync_down   (.clk(CLK), .rst(RST), .din(DOWN_LIMIT),  .dout(down_limit));

  // ****************************************
  // Door sequence.
  // ****************************************
  always_comb
  begin
    next_state = state;
    lamp_set   = 1'b0;
    case (state)
      DOOR_DOWN:
      begin
        if (door_button)
        begin
          next_state = PUSH_UP_WAIT;
        end
      end
      PUSH_UP_WAIT:
      begin
        if (!door_button)
        begin
          next_state = RAISING;
          lamp_set   = 1'b1;
        end
      end
      RAISING:
      begin
        if (up_limit)
        begin
          next_state = DOOR_UP;
        end
      end
      DOOR_UP:
      begin
        if (door_button)
        begin
          next_state = PUSH_DOWN_WAIT;
        end
      end
      PUSH_DOWN_WAIT:
      begin
        if (!door_button)
        begin
          next_state = LOWERING;
          lamp_set   = 1'b1;
        end
      end
      LOWERING:
      begin
        if (down_limit)
        begin
          next_state = DOOR_DOWN;
        end
      end
      default:
      begin
        next_state = DOOR_DOWN;
      end
    endcase
    next_raise = (next_state == RAISING);
    next_lower = (next_state == LOWERING);
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      state     <= DOOR_DOWN;
      RAISE_CMD <= 1'b0;
      LOWER_CMD <= 1'b0;
    end
    else
    begin
      state     <= next_state;
      RAISE_CMD <= next_raise;
      LOWER_CMD <= next_lower;
    end
  end

  // ****************************************
  // Safety lamp, a parallel process.
  // ****************************************
  assign lamp_timer_done = lamp_state && (count == COUNT_LAST) && (tick == TICK_LAST);

  always_comb
  begin
    next_lamp_state = lamp_state;
    next_tick       = tick;
    next_count      = count;
    if (lamp_state)
    begin
      if (tick == TICK_LAST)
      begin
        next_tick  = '0;
        next_count = count + 1'b1;
      end
      else
      begin
        next_tick = tick + 1'b1;
      end
    end
    if (lamp_timer_done)
    begin
      next_lamp_state = 1'b0;
      next_tick       = '0;
      next_count      = '0;
    end
    if (lamp_set && !lamp_state)
    begin
      next_lamp_state = 1'b1;
      next_tick       = '0;
      next_count      = '0;
    end
    else if (lamp_set)
    begin
      next_lamp_state = 1'b1;
    end
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      lamp_state <= 1'b0;
      tick       <= '0;
      count      <= '0;
      LAMP_OUT   <= 1'b0;
    end
    else
    begin
      lamp_state <= next_lamp_state;
      tick       <= next_tick;
      count      <= next_count;
      LAMP_OUT   <= next_lamp_state;
    end
  end

  // ****************************************
  // Checks.
  // ****************************************
  property p_cmd_exclusive;
    @(posedge CLK) disable iff (RST) !(RAISE_CMD && LOWER_CMD);
  endproperty
  a_cmd_exclusive: assert property (p_cmd_exclusive) else $error("raise and lower both active");

  property p_raise_state;
    @(posedge CLK) disable iff (RST) RAISE_CMD == (state == RAISING);
  endproperty
  a_raise_state: assert property (p_raise_state) else $error("raise command mismatch");

  property p_lower_state;
    @(posedge CLK) disable iff (RST) LOWER_CMD == (state == LOWERING);
  endproperty
  a_lower_state: assert property (p_lower_state) else $error("lower command mismatch");

  property p_up_press;
    @(posedge CLK) disable iff (RST) (state == DOOR_DOWN && door_button) |=> state == PUSH_UP_WAIT;
  endproperty
  a_up_press: assert property (p_up_press) else $error("press from down not taken");

  property p_down_press;
    @(posedge CLK) disable iff (RST) (state == DOOR_UP && door_button) |=> state == PUSH_DOWN_WAIT;
  endproperty
  a_down_press: assert property (p_down_press) else $error("press from up not taken");

  property p_raise_start;
    @(posedge CLK) disable iff (RST)
      (state == PUSH_UP_WAIT && !door_button) |=> (state == RAISING && RAISE_CMD && lamp_state);
  endproperty
  a_raise_start: assert property (p_raise_start) else $error("release did not start raising");

  property p_up_limit;
    @(posedge CLK) disable iff (RST) (state == RAISING && up_limit) |=> (state == DOOR_UP && !RAISE_CMD);
  endproperty
  a_up_limit: assert property (p_up_limit) else $error("up limit ignored");

  property p_down_limit;
    @(posedge CLK) disable iff (RST)
      (state == LOWERING && down_limit) |=> (state == DOOR_DOWN && !LOWER_CMD);
  endproperty
  a_down_limit: assert property (p_down_limit) else $error("down limit ignored");

  property p_lamp_out;
    @(posedge CLK) disable iff (RST) LAMP_OUT == lamp_state;
  endproperty
  a_lamp_out: assert property (p_lamp_out) else $error("lamp output mismatch");

  property p_lamp_expire;
    @(posedge CLK) disable iff (RST) (lamp_timer_done && !lamp_set) |=> !lamp_state;
  endproperty
  a_lamp_expire: assert property (p_lamp_expire) else $error("lamp did not expire");

  property p_lamp_hold;
    @(posedge CLK) disable iff (RST) ($rose(lamp_state)) |-> (count == 0 && tick == 0);
  endproperty
  a_lamp_hold: assert property (p_lamp_hold) else $error("lamp timer not cleared on start");
endmodule : garage_door_controller

// ==== core/garage_door_pkg.sv ====
/*
  Types shared by the garage door controller.
  Assumes nothing of its surroundings.
*/
package garage_door_pkg;
  typedef enum logic [2:0] {
    DOOR_DOWN,
    PUSH_UP_WAIT,
    RAISING,
    DOOR_UP,
    PUSH_DOWN_WAIT,
    LOWERING
  } door_state_t;
endpackage : garage_door_pkg

// ==== core/input_sync.sv ====
/*
  Three-stage synchroniser with agreement filter for one switch input.
  Assumes the input is asynchronous to CLK.
*/
`timescale 1ns/1ps
module input_sync
(
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst,
  // Raw input and filtered result.
  input  wire logic din,
  output logic      dout
);
  logic [2:0] stage;
  logic [2:0] next_stage;
  logic       next_dout;

  always_comb
  begin
    next_stage = {stage[1:0], din};
    next_dout  = dout;
    if (stage[1] == stage[2])
    begin
      next_dout = stage[2];
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      stage <= 3'h0;
      dout  <= 1'b0;
    end
    else
    begin
      stage <= next_stage;
      dout  <= next_dout;
    end
  end
endmodule : input_sync

// ==== dv/door_model.sv ====
/*
  Behavioural door, motor and limit switches for the garage door controller.
  Assumes the commands are registered on the same clock; door starts closed.
*/
`timescale 1ns/1ps
module door_model
#(
  parameter int TRAVEL = 60
)
(
  // Clock.
  input  wire logic clk,
  // Motor commands.
  input  wire logic raise_cmd,
  input  wire logic lower_cmd,
  // Limit switches.
  output logic      up_limit,
  output logic      down_limit
);
  int pos = 0;

  always @(posedge clk)
  begin
    if (raise_cmd && !lower_cmd && pos < TRAVEL) pos <= pos + 1;
    else if (lower_cmd && !raise_cmd && pos > 0) pos <= pos - 1;
  end

  assign up_limit   = (pos == TRAVEL);
  assign down_limit = (pos == 0);
endmodule : door_model

// ==== dv/testbench.sv ====
/*
  Self-checking testbench for the garage door controller.
  Assumes a 100 MHz clock and the door model on the far side.
*/
`timescale 1ns/1ps
module testbench;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic DOOR_BUTTON = 1'b0;
  logic UP_LIMIT;
  logic DOWN_LIMIT;
  logic RAISE_CMD;
  logic LOWER_CMD;
  logic LAMP_OUT;
  int   num_errors = 0;
  int   num_checks = 0;

  always #5 CLK = ~CLK;

  garage_door_controller u_garage_door_controller (.CLK(CLK), .RST(RST), .DOOR_BUTTON(DOOR_BUTTON),
    .UP_LIMIT(UP_LIMIT), .DOWN_LIMIT(DOWN_LIMIT), .RAISE_CMD(RAISE_CMD), .LOWER_CMD(LOWER_CMD),
    .LAMP_OUT(LAMP_OUT));

  door_model u_door_model (.clk(CLK), .raise_cmd(RAISE_CMD), .lower_cmd(LOWER_CMD),
    .up_limit(UP_LIMIT), .down_limit(DOWN_LIMIT));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input string nm, input logic exp, input logic got);
    num_checks++;
    if (exp !== got)
    begin
      $display("MISMATCH %s expected %b seen %b", nm, exp, got);
      num_errors++;
    end
  endtask : chk

  task automatic wait_for(input int idx, input logic val, input string nm);
    int         n;
    logic [2:0] outs;
    n    = 0;
    outs = {RAISE_CMD, LOWER_CMD, LAMP_OUT};
    while (outs[idx] !== val && n < 200)
    begin
      @(posedge CLK);
      n++;
      outs = {RAISE_CMD, LOWER_CMD, LAMP_OUT};
    end
    chk(nm, val, outs[idx]);
  endtask : wait_for

  task automatic press_release();
    @(posedge CLK) DOOR_BUTTON <= 1'b1;
    repeat (8) @(posedge CLK);
    DOOR_BUTTON <= 1'b0;
  endtask : press_release

  task automatic check_idle();
    chk("raise", 1'b0, RAISE_CMD);
    chk("lower", 1'b0, LOWER_CMD);
    chk("lamp", 1'b0, LAMP_OUT);
  endtask : check_idle

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic scen_raise();
    @(posedge CLK) DOOR_BUTTON <= 1'b1;
    repeat (12) @(posedge CLK);
    chk("raise held", 1'b0, RAISE_CMD);
    DOOR_BUTTON <= 1'b0;
    wait_for(2, 1'b1, "raise");
    chk("lower", 1'b0, LOWER_CMD);
    wait_for(0, 1'b1, "lamp");
    press_release();
    repeat (8) @(posedge CLK);
    chk("raise ignores button", 1'b1, RAISE_CMD);
    wait_for(2, 1'b0, "raise stop");
    repeat (8) @(posedge CLK);
    chk("lower at up", 1'b0, LOWER_CMD);
    chk("lamp on", 1'b1, LAMP_OUT);
  endtask : scen_raise

  task automatic scen_lower();
    press_release();
    wait_for(1, 1'b1, "lower");
    chk("raise", 1'b0, RAISE_CMD);
    chk("lamp", 1'b1, LAMP_OUT);
    wait_for(1, 1'b0, "lower stop");
    repeat (8) @(posedge CLK);
    chk("raise at down", 1'b0, RAISE_CMD);
  endtask : scen_lower

  task automatic scen_reset();
    press_release();
    wait_for(2, 1'b1, "raise");
    repeat (10) @(posedge CLK);
    RST <= 1'b1;
    repeat (2) @(posedge CLK);
    check_idle();
    RST <= 1'b0;
    repeat (3) @(posedge CLK);
    press_release();
    wait_for(2, 1'b1, "raise after reset");
    wait_for(2, 1'b0, "raise stop");
  endtask : scen_reset

  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done

  initial
  begin
    #500us;
    num_errors++;
    test_done();
  end

  initial
  begin
    repeat (20) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    check_idle();
    scen_raise();
    scen_lower();
    scen_reset();
    test_done();
  end
endmodule : testbench
